// File: lbhi_pkg.sv
// Shared constants for the local bus host interface
package lbhi_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   // Host-side controller register offsets (AXI4-Lite byte addresses)
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_WDATA = 8'h08;
   localparam logic [7:0] REG_RDATA = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_IRQ_STAT = 8'h14;
   localparam logic [7:0] REG_IRQ_MASK = 8'h18;
   // Control register fields
   localparam int CTRL_GO = 0;
   localparam int CTRL_WRITE = 1;
   localparam int CTRL_DATASEL = 2;
   localparam int CTRL_MODE_LSB = 4;
   // Bus styles
   typedef enum logic [1:0]
   {
      LBHI_SYNC = 2'b00,
      LBHI_ASYNC = 2'b01,
      LBHI_BURST = 2'b10
   } lbhi_mode_t;
   // Interrupt status bits
   localparam int IRQ_DONE = 0;
   localparam int IRQ_DEV = 1;
   localparam int IRQ_W = 2;
   // Base address reset value, high byte compared against A15-A8
   localparam logic [7:0] BASE_HIGH_RST = 8'h03;
   // Host bus clock limit and divider from the 4 ns core clock
   localparam int CORE_PERIOD_NS = 4;
   localparam int BUS_CLK_MAX_MHZ = 50;
   localparam int BUS_CLK_MIN_NS = 1000 / BUS_CLK_MAX_MHZ;
   localparam int BUS_HALF_CYC = (BUS_CLK_MIN_NS + 2 * CORE_PERIOD_NS - 1)
                                 / (2 * CORE_PERIOD_NS);
   // Device wait states inserted before ready
   localparam int WAIT_CYC = 2;
   // Register space of the device's queue data pair
   localparam logic [15:0] QDATA_LOW_OFS = 16'h0008;
endpackage : lbhi_pkg

// File: lbhi_if.sv
// Pin-level carrier between local bus host and device
`timescale 1ns/100ps
interface lbhi_if;
   import lbhi_pkg::*;
   logic busClk;
   logic [ADDR_W-1:1] addr;
   logic addrQualN;
   logic addrStrobeN;
   logic dataSelN;
   logic readStrobeN;
   logic writeStrobeN;
   logic syncWriteRead;
   logic command_cycle_n;
   logic busStyleStrap;
   logic [DATA_W-1:0] hostData;
   logic hostDataOe;
   logic [DATA_W-1:0] devData;
   logic devDataOe;
   logic syncReadyN;
   logic asyncReady;
   logic irqOutN;
   logic localDevHitN;
   wire [DATA_W-1:0] dataBus = hostDataOe ? hostData
                             : (devDataOe ? devData : '0);
   modport host
   (
      output busClk, addr, addrQualN, addrStrobeN, dataSelN, readStrobeN,
      output writeStrobeN, syncWriteRead, command_cycle_n, busStyleStrap,
      output hostData, hostDataOe,
      input dataBus, syncReadyN, asyncReady, irqOutN, localDevHitN
   );
   modport device
   (
      input busClk, addr, addrQualN, addrStrobeN, dataSelN, readStrobeN,
      input writeStrobeN, syncWriteRead, command_cycle_n, busStyleStrap, dataBus,
      output devData, devDataOe, syncReadyN, asyncReady, irqOutN,
      output localDevHitN
   );
endinterface : lbhi_if

// File: lbhi_device.sv
// Device end: decode, data port, ready signalling and interrupt
`timescale 1ns/100ps
module lbhi_device
   import lbhi_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Host pins
   lbhi_if.device bus,
   // Core side
   input wire logic [7:0] baseHigh,
   input wire logic irqPending,
   input wire logic [DATA_W-1:0] coreRdata,
   output logic coreWrite,
   output logic [DATA_W-1:0] coreWdata,
   output logic [ADDR_W-1:1] coreAddr,
   output logic coreDataPort,
   output lbhi_mode_t mode
);
   logic [1:0] clkS, rdS, wrS, cycS, adsS, strapS;
   logic [1:0] swrS;
   logic clkQ, adsQ, rdQ, wrQ;
   logic [ADDR_W-1:1] addrLatch;
   logic qualLatch;
   logic [3:0] waitCnt;
   logic busy, dataOe, ack;
   logic [DATA_W-1:0] rdata;

   // Combinational hit, no register stage on the address path
   wire decodeHit = !bus.addrQualN
                    && bus.addr[15:4] == {baseHigh, 4'h0};
   assign bus.localDevHitN = !decodeHit;
   wire busRise = clkS[1] && !clkQ;
   wire adsRise = adsS[1] && !adsQ;
   // Address as captured at the strobe's rise, bypassed on that very cycle
   wire [ADDR_W-1:1] accAddr = adsRise ? bus.addr : addrLatch;
   wire accQualN = adsRise ? bus.addrQualN : qualLatch;
   wire latchHit = !accQualN && accAddr[15:4] == {baseHigh, 4'h0};
   wire selected = !bus.dataSelN || latchHit;
   wire rdFall = !rdS[1] && rdQ;
   wire wrFall = !wrS[1] && wrQ;
   wire syncStart = mode != LBHI_ASYNC && busRise && !cycS[1] && !busy;
   wire asyncStart = mode == LBHI_ASYNC && (rdFall || wrFall) && !busy;
   wire startAcc = (syncStart || asyncStart) && selected;

   always_ff @(posedge core_clk)
   begin
      clkS <= {clkS[0], bus.busClk};
      rdS <= {rdS[0], bus.readStrobeN};
      wrS <= {wrS[0], bus.writeStrobeN};
      cycS <= {cycS[0], bus.command_cycle_n};
      adsS <= {adsS[0], bus.addrStrobeN};
      swrS <= {swrS[0], bus.syncWriteRead};
      strapS <= {strapS[0], bus.busStyleStrap};
      clkQ <= clkS[1];
      adsQ <= adsS[1];
      rdQ <= rdS[1];
      wrQ <= wrS[1];
   end

   // Strap taken after release; low or floating means synchronous
   always_ff @(posedge core_clk)
   begin
      if (reset)
         mode <= LBHI_SYNC;
      else if (strapS[1])
         mode <= cycS[1] ? LBHI_ASYNC : LBHI_BURST;
      else
         mode <= LBHI_SYNC;
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         addrLatch <= '0;
         qualLatch <= 1'b1;
      end
      else if (adsRise)
      begin
         addrLatch <= bus.addr;
         qualLatch <= bus.addrQualN;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         busy <= 1'b0;
         waitCnt <= '0;
         ack <= 1'b0;
         dataOe <= 1'b0;
         coreWrite <= 1'b0;
         coreWdata <= '0;
         coreAddr <= '0;
         coreDataPort <= 1'b0;
         rdata <= '0;
      end
      else
      begin
         coreWrite <= 1'b0;
         if (startAcc)
         begin
            busy <= 1'b1;
            ack <= 1'b0;
            waitCnt <= 4'(WAIT_CYC);
            coreDataPort <= !bus.dataSelN;
            coreAddr <= !bus.dataSelN ? QDATA_LOW_OFS[ADDR_W-1:1]
                        : accAddr;
            dataOe <= mode == LBHI_ASYNC ? !rdS[1] : !swrS[1];
         end
         else if (busy && waitCnt != 0)
            waitCnt <= waitCnt - 4'h1;
         else if (busy)
         begin
            // Sync modes finish on a bus clock edge so ready stays synchronous to it; async finishes at once
            if (mode == LBHI_ASYNC || busRise)
            begin
               busy <= 1'b0;
               ack <= 1'b1;
               rdata <= coreRdata;
               coreWrite <= mode == LBHI_ASYNC ? !wrS[1] : swrS[1];
               coreWdata <= bus.dataBus;
            end
         end
         else if (mode == LBHI_ASYNC ? (rdS[1] && wrS[1]) : busRise)
         begin
            // Writes need the acknowledge too, so it is kept apart from dataOe
            dataOe <= 1'b0;
            ack <= 1'b0;
         end
      end
   end

   // Ready falls on completion; burst keeps it low through wait states
   assign bus.syncReadyN = mode == LBHI_BURST ? !busy
                           : !ack;
   assign bus.asyncReady = !busy;
   assign bus.irqOutN = !irqPending;
   assign bus.devData = rdata;
   assign bus.devDataOe = dataOe && !busy;
endmodule : lbhi_device

// File: lbhi_host.sv
// Host end: AXI4-Lite controlled local bus master
`timescale 1ns/100ps
module lbhi_host
   import lbhi_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Interrupt and bus pins
   output logic irq,
   lbhi_if.host bus
);
   typedef enum logic [1:0]
   {
      S_IDLE = 2'b00,
      S_ADDR = 2'b01,
      S_CMD = 2'b10,
      S_DONE = 2'b11
   } lbhi_state_t;
   lbhi_state_t state;
   logic [31:0] ctrl, addrReg, wdata, wdReg, rdata, mask;
   logic [IRQ_W-1:0] stat;
   logic [3:0] div;
   logic clkOut, awHeld, wHeld;
   logic [7:0] awAddr;
   logic [1:0] rdyS, ardyS, irqS;
   logic rdyQ, ardyLow;
   wire tick = div == 4'(BUS_HALF_CYC - 1);
   wire rise = tick && !clkOut;
   wire async = ctrl[CTRL_MODE_LSB+1:CTRL_MODE_LSB] == LBHI_ASYNC;
   wire doWrite = awHeld && wHeld && !s_axi_bvalid;
   wire done = state == S_DONE;
   wire devEvent = !irqS[1];
   wire burst = ctrl[CTRL_MODE_LSB+1:CTRL_MODE_LSB] == LBHI_BURST;
   // Idle ready is high, so it only counts once seen low in this command
   wire asyncDone = ardyS[1] && ardyLow;
   // Burst ends on ready rising after its wait states, else on a fall
   wire syncDone = burst ? (rdyS[1] && !rdyQ) : (!rdyS[1] && rdyQ);
   wire readyNow = async ? asyncDone : syncDone;

   assign s_axi_awready = !awHeld;
   assign s_axi_wready = !wHeld;
   assign s_axi_arready = !s_axi_rvalid;
   assign s_axi_bresp = 2'b00;
   assign s_axi_rresp = 2'b00;
   assign irq = |(stat & mask[IRQ_W-1:0]);

   always_ff @(posedge core_clk)
   begin
      rdyS <= {rdyS[0], bus.syncReadyN};
      ardyS <= {ardyS[0], bus.asyncReady};
      irqS <= {irqS[0], bus.irqOutN};
      rdyQ <= rdyS[1];
   end

   // Bus clock from a divider, within the 50 MHz limit, sync modes only
   always_ff @(posedge core_clk)
   begin
      if (reset || async)
      begin
         div <= '0;
         clkOut <= 1'b0;
      end
      else
      begin
         div <= tick ? 4'h0 : div + 4'h1;
         if (tick)
            clkOut <= !clkOut;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddr <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         ctrl <= '0;
         addrReg <= '0;
         wdata <= '0;
         wdReg <= '0;
         mask <= '0;
         stat <= '0;
      end
      else
      begin
         if (s_axi_awvalid && !awHeld)
         begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !wHeld)
         begin
            wHeld <= 1'b1;
            wdata <= s_axi_wdata;
         end
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (done)
            ctrl[CTRL_GO] <= 1'b0;
         // Set wins over a write-one clear in the same cycle
         stat <= stat & ~((doWrite && awAddr == REG_IRQ_STAT)
                 ? wdata[IRQ_W-1:0] : '0);
         if (done)
            stat[IRQ_DONE] <= 1'b1;
         if (devEvent)
            stat[IRQ_DEV] <= 1'b1;
         if (doWrite)
         begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (awAddr == REG_CTRL)
               ctrl <= wdata;
            else if (awAddr == REG_ADDR)
               addrReg <= wdata;
            else if (awAddr == REG_WDATA)
               wdReg <= wdata;
            else if (awAddr == REG_IRQ_MASK)
               mask <= wdata;
         end
         if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
         else if (s_axi_arvalid && !s_axi_rvalid)
         begin
            s_axi_rvalid <= 1'b1;
            case (s_axi_araddr)
               REG_CTRL: s_axi_rdata <= ctrl;
               REG_ADDR: s_axi_rdata <= addrReg;
               REG_WDATA: s_axi_rdata <= wdReg;
               REG_RDATA: s_axi_rdata <= rdata;
               REG_STATUS: s_axi_rdata <= {30'h0, devEvent, state != S_IDLE};
               REG_IRQ_STAT: s_axi_rdata <= {30'h0, stat};
               REG_IRQ_MASK: s_axi_rdata <= mask;
               default: s_axi_rdata <= 32'h0;
            endcase
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         state <= S_IDLE;
         rdata <= '0;
         ardyLow <= 1'b0;
      end
      else
      begin
         ardyLow <= state == S_CMD && (ardyLow || !ardyS[1]);
         case (state)
            S_IDLE:
               if (ctrl[CTRL_GO] && !done)
                  state <= S_ADDR;
            S_ADDR:
               if (async || rise)
                  state <= S_CMD;
            S_CMD:
               if (readyNow)
               begin
                  state <= S_DONE;
                  rdata <= bus.dataBus;
               end
            S_DONE:
               state <= S_IDLE;
            default:
               state <= S_IDLE;
         endcase
      end
   end

   wire active = state == S_CMD;
   wire isWrite = ctrl[CTRL_WRITE];
   assign bus.busClk = clkOut;
   assign bus.busStyleStrap = ctrl[CTRL_MODE_LSB+1:CTRL_MODE_LSB] != LBHI_SYNC;
   assign bus.addr = addrReg[ADDR_W-1:1];
   assign bus.addrQualN = 1'b0;
   assign bus.addrStrobeN = state != S_ADDR;
   assign bus.dataSelN = !ctrl[CTRL_DATASEL];
   assign bus.readStrobeN = !(async && active && !isWrite);
   assign bus.writeStrobeN = !(async && active && isWrite);
   assign bus.syncWriteRead = isWrite;
   // Burst: high for reads, low for writes; async holds it high; sync gives a command-phase strobe
   assign bus.command_cycle_n = burst ? !isWrite
                       : (async ? 1'b1 : !active);
   assign bus.hostData = wdReg;
   assign bus.hostDataOe = active && isWrite;
endmodule : lbhi_host

// File: lbhi_asserts.sv
// Pin-level checks between host end and device end
`timescale 1ns/100ps
module lbhi_asserts
   import lbhi_pkg::*;
(
   // Clock, reset and core side
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [7:0] baseHigh,
   input wire logic irqPending,
   // Bus pins
   input wire logic busClk,
   input wire logic [ADDR_W-1:1] addr,
   input wire logic addrQualN,
   input wire logic addrStrobeN,
   input wire logic dataSelN,
   input wire logic readStrobeN,
   input wire logic writeStrobeN,
   input wire logic command_cycle_n,
   input wire logic busStyleStrap,
   input wire logic hostDataOe,
   input wire logic devDataOe,
   input wire logic syncReadyN,
   input wire logic asyncReady,
   input wire logic irqOutN,
   input wire logic localDevHitN
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);
   wire logic decodeHit;
   wire logic busIdle;
   assign decodeHit = !addrQualN && addr[15:4] == {baseHigh, 4'h0};
   assign busIdle = readStrobeN && writeStrobeN && command_cycle_n && addrStrobeN;
   a_hit_decode: assert property (localDevHitN == !decodeHit)
      else $error("local hit differs from decode");
   a_irq_low: assert property (irqPending [*3] |-> !irqOutN)
      else $error("irq out not low while pending");
   a_irq_high: assert property (!irqPending [*3] |-> irqOutN)
      else $error("irq out low with nothing pending");
   a_no_contend: assert property (devDataOe |-> !hostDataOe)
      else $error("both ends drive data");
   a_miss_quiet: assert property
      ((localDevHitN && dataSelN) [*3] |-> !devDataOe)
      else $error("device drives data when not addressed");
   a_ready_edge: assert property
      ($fell(syncReadyN) && !busStyleStrap
       |-> $past(busClk) || $past(busClk, 2) || $past(busClk, 3))
      else $error("ready fall not tied to bus clock");
   a_ready_bound: assert property
      ($fell(command_cycle_n) && !busStyleStrap |-> ##[1:60] $fell(syncReadyN))
      else $error("sync ready never came");
   a_idle_ready: assert property
      (busIdle [*8] |-> syncReadyN && asyncReady)
      else $error("ready outputs not idle");
   cover property ($fell(syncReadyN));
   cover property (!dataSelN && localDevHitN);
   cover property (!irqOutN);
endmodule : lbhi_asserts

// File: testbench.sv
// Register-level tests of host and device ends joined by the bus
`timescale 1ns/100ps
module testbench;
   import lbhi_pkg::*;
   logic core_clk, reset, irqPending;
   logic [7:0] awAddr, arAddr, baseHigh;
   logic [31:0] wData, rData, coreRdata, coreWdata, v;
   logic [ADDR_W-1:1] coreAddr;
   logic awValid, awReady, wValid, wReady, bValid, bReady;
   logic arValid, arReady, rValid, rReady, irq, coreDataPort, coreWrite;
   lbhi_mode_t mode;
   int fails = 0;
   int testsRun = 0;
   int writeCount = 0;
   lbhi_if lbhi_if_inst ();
   lbhi_device lbhi_device_inst (.core_clk, .reset, .bus(lbhi_if_inst),
      .baseHigh, .irqPending, .coreRdata, .coreWrite, .coreWdata,
      .coreAddr, .coreDataPort, .mode);
   lbhi_host lbhi_host_inst (.core_clk, .reset, .s_axi_awaddr(awAddr),
      .s_axi_awvalid(awValid), .s_axi_awready(awReady),
      .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
      .s_axi_wready(wReady), .s_axi_bresp(), .s_axi_bvalid(bValid),
      .s_axi_bready(bReady), .s_axi_araddr(arAddr),
      .s_axi_arvalid(arValid), .s_axi_arready(arReady),
      .s_axi_rdata(rData), .s_axi_rresp(), .s_axi_rvalid(rValid),
      .s_axi_rready(rReady), .irq, .bus(lbhi_if_inst));
   lbhi_asserts lbhi_asserts_inst (.core_clk, .reset, .baseHigh,
      .irqPending, .busClk(lbhi_if_inst.busClk),
      .addr(lbhi_if_inst.addr), .addrQualN(lbhi_if_inst.addrQualN),
      .addrStrobeN(lbhi_if_inst.addrStrobeN),
      .dataSelN(lbhi_if_inst.dataSelN),
      .readStrobeN(lbhi_if_inst.readStrobeN),
      .writeStrobeN(lbhi_if_inst.writeStrobeN),
      .command_cycle_n(lbhi_if_inst.command_cycle_n),
      .busStyleStrap(lbhi_if_inst.busStyleStrap),
      .hostDataOe(lbhi_if_inst.hostDataOe),
      .devDataOe(lbhi_if_inst.devDataOe),
      .syncReadyN(lbhi_if_inst.syncReadyN),
      .asyncReady(lbhi_if_inst.asyncReady),
      .irqOutN(lbhi_if_inst.irqOutN),
      .localDevHitN(lbhi_if_inst.localDevHitN));
   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   // Each bus write shows as exactly one core write pulse
   always @(posedge core_clk)
      if (coreWrite === 1'b1)
         writeCount <= writeCount + 1;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      testsRun++;
      if (seen !== exp)
      begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", testsRun, fails);
      if (fails == 0 && testsRun > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : wrap_up
   // Address and data offered together, each dropped once taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      awAddr <= a;
      wData <= d;
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      do
      begin
         @(posedge core_clk);
         if (awReady)
            awValid <= 1'b0;
         if (wReady)
            wValid <= 1'b0;
      end
      while (!bValid);
      bReady <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk);
      arAddr <= a;
      arValid <= 1'b1;
      rReady <= 1'b1;
      do
      begin
         @(posedge core_clk);
         if (arReady)
            arValid <= 1'b0;
      end
      while (!rValid);
      d = rData;
      rReady <= 1'b0;
   endtask : axi_rd
   // Start a bus cycle and poll busy with a bounded count
   task automatic run_op(input logic [31:0] ctrl);
      logic [31:0] s;
      axi_wr(REG_CTRL, ctrl);
      s = 32'h1;
      for (int n = 0; n < 100 && s[0] !== 1'b0; n++)
         axi_rd(REG_STATUS, s);
      check(s & 32'h1, 32'h0);
   endtask : run_op
   initial
   begin
      repeat (50000) @(posedge core_clk);
      fails++;
      wrap_up();
   end
   initial
   begin
      reset = 1'b1;
      {awValid, wValid, bReady, arValid, rReady, irqPending} = '0;
      {awAddr, arAddr, wData} = '0;
      baseHigh = BASE_HIGH_RST;
      coreRdata = 32'h0;
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      axi_wr(REG_ADDR, 32'h0304);
      axi_wr(REG_WDATA, 32'hA5A55A5A);
      run_op(32'h3);
      check(coreWdata, 32'hA5A55A5A);
      check({17'h0, coreAddr}, 32'h182);
      check({31'h0, coreDataPort}, 32'h0);
      check({30'h0, mode}, {30'h0, LBHI_SYNC});
      check(writeCount, 32'h1);
      coreRdata <= 32'h12345678;
      run_op(32'h1);
      axi_rd(REG_RDATA, v);
      check(v, 32'h12345678);
      check(writeCount, 32'h1);
      // Address outside the window: only the data port select reaches
      axi_wr(REG_ADDR, 32'h7FF0);
      axi_wr(REG_WDATA, 32'h0F0F00FF);
      run_op(32'h7);
      check({31'h0, coreDataPort}, 32'h1);
      check(coreWdata, 32'h0F0F00FF);
      coreRdata <= 32'h00C3A5F0;
      run_op(32'h5);
      axi_rd(REG_RDATA, v);
      check(v, 32'h00C3A5F0);
      axi_wr(REG_IRQ_STAT, 32'h3);
      axi_wr(REG_IRQ_MASK, 32'h2);
      irqPending <= 1'b1;
      repeat (4) @(posedge core_clk);
      axi_rd(REG_STATUS, v);
      check(v & 32'h2, 32'h2);
      check({31'h0, irq}, 32'h1);
      irqPending <= 1'b0;
      repeat (4) @(posedge core_clk);
      axi_wr(REG_IRQ_STAT, 32'h2);
      axi_rd(REG_IRQ_STAT, v);
      check(v & 32'h2, 32'h0);
      check({31'h0, irq}, 32'h0);
      // Done is latched but masked until the mask opens
      axi_wr(REG_ADDR, 32'h0304);
      run_op(32'h3);
      check({31'h0, irq}, 32'h0);
      axi_wr(REG_IRQ_MASK, 32'h3);
      check({31'h0, irq}, 32'h1);
      axi_rd(8'h1C, v);
      check(v, 32'h0);
      run_op(32'h13);
      check({31'h0, mode == LBHI_SYNC}, 32'h0);
      check(coreWdata, 32'h0F0F00FF);
      check(writeCount, 32'h4);
      wrap_up();
   end
endmodule : testbench
